// file: pgd_pkg.sv
// Package for the page-mode DRAM controller: pin widths, timing counts and byte-lane codes.
// Assumes a 250 MHz controller clock; all counts derive from nanosecond figures.
package pgd_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 4;
  localparam int unsigned ADDR_W         = 9;
  localparam int unsigned DATA_W         = 16;
  localparam int unsigned ROWS           = 512;
  // Minimum times round up; maximum times and the power-up pause round down.
  localparam int unsigned ROW_ACTIVE_WIDTH_NS      = 70;
  localparam int unsigned ROW_ACTIVE_WIDTH_MAX_NS  = 10000;
  localparam int unsigned ROW_ACTIVE_WIDTH_PAGE_NS = 100000;
  localparam int unsigned RANDOM_CYCLE_TIME_NS     = 130;
  localparam int unsigned ROW_PRECHARGE_TIME_NS    = 50;
  localparam int unsigned CBR_SETUP_TIME_NS        = 10;
  localparam int unsigned CBR_HOLD_TIME_NS         = 20;
  localparam int unsigned ROW_ACCESS_NS            = 70;
  localparam int unsigned COL_ACCESS_NS            = 20;
  localparam int unsigned PAGE_CYCLE_TIME_NS       = 45;
  localparam int unsigned PAGE_RMW_CYCLE_TIME_NS   = 100;
  localparam int unsigned OE_OFF_NS                = 20;
  localparam int unsigned REFRESH_PERIOD_NS        = 8000000;
  localparam int unsigned POWERUP_PAUSE_NS         = 200000;
  localparam int unsigned INIT_REFRESHES           = 8;

  localparam int unsigned T_RAS_MIN  = (ROW_ACTIVE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_RAS_MAX  = ROW_ACTIVE_WIDTH_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned T_RASP_MAX = ROW_ACTIVE_WIDTH_PAGE_NS / CLK_PERIOD_NS;
  localparam int unsigned T_RC       = (RANDOM_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_RP       = (ROW_PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_CSR      = (CBR_SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_CHR      = (CBR_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_RAC      = (ROW_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_CAC      = (COL_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_PC       = (PAGE_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_PRWC     = (PAGE_RMW_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_OEZ      = (OE_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REF_INTERVAL_DEF = REFRESH_PERIOD_NS / ROWS / CLK_PERIOD_NS;
  localparam int unsigned POWERUP_DEF      = POWERUP_PAUSE_NS / CLK_PERIOD_NS;

  localparam logic [1:0] BYTE_LOWER = 2'h1;
  localparam logic [1:0] BYTE_UPPER = 2'h2;
endpackage : pgd_pkg

// file: pgd_tmr_if.sv
// Interface carrying a load/expire handshake between the sequencer and its interval timer.
// Assumes both ends run on the controller clock.
`timescale 1ns/1ns
interface pgd_tmr_if;
  logic        load;
  logic [15:0] count;
  logic        done;
  modport seq (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface : pgd_tmr_if

// file: pgd_timer.sv
// Down-counter that flags when a loaded number of cycles has elapsed.
// Assumes a load of N raises done N cycles later, counted on enabled edges.
`timescale 1ns/1ns
module pgd_timer (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic ce,
  pgd_tmr_if.tmr    t
);
  logic [15:0] cnt_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_q <= 16'h0;
    end else if (ce) begin
      if (t.load) begin
        cnt_q <= t.count;
      end else if (cnt_q != 16'h0) begin
        cnt_q <= cnt_q - 16'h1;
      end
    end
  end

  assign t.done = (cnt_q == 16'h0) && !t.load;
endmodule : pgd_timer

// file: pgd_ctrl.sv
// Host-side controller for a 256K x 16 page-mode DRAM: strobes, multiplexed address, refresh.
// Assumes a user port with a request/ready handshake and DRAM data pins returned through sync flops.
`timescale 1ns/1ns
// How it works
// - Two column strobes select byte lanes
// - Row strobe low 70 ns to 10000 ns
// - Page burst row strobe at most 100K ns
// - Random cycles at least 130 ns apart
// - Column strobe 10 ns before, 20 ns after
// - Page column cycles at least 45 ns
// - Page read-modify-write 100 ns per column
// - Nine row then nine column bits
// - Early write keeps device outputs floating
// - Wait 200 us then eight refreshes
module pgd_ctrl #(
  parameter int unsigned REF_INTERVAL = pgd_pkg::REF_INTERVAL_DEF,
  parameter int unsigned POWERUP      = pgd_pkg::POWERUP_DEF
) (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic        req_rmw,
  input  wire logic [1:0]  req_bytes,
  input  wire logic [17:0] req_addr,
  input  wire logic [15:0] req_wdata,
  output logic             req_ready,
  output logic             rsp_valid,
  output logic [15:0]      rsp_rdata,
  output logic             init_done,
  output logic             row_strobe_n,
  output logic             lower_column_strobe_n,
  output logic             upper_column_strobe_n,
  output logic             write_enable_n,
  output logic             output_enable_n,
  output logic [8:0]       mux_addr,
  input  wire logic [15:0] data_lanes_i,
  output logic [15:0]      data_lanes_o,
  output logic [15:0]      data_lanes_oe
);
  // The interval and pause counters are 16 and 24 bits wide; larger settings would wrap silently.
  if (REF_INTERVAL < pgd_pkg::T_RC || REF_INTERVAL > 16'hffff || POWERUP > 24'hffffff) begin : g_bad_timing
    $error("pgd_ctrl: timing parameter out of range");
  end

  typedef enum logic [3:0] {S_PWR, S_IDLE, S_RAS, S_CAS, S_WAIT, S_OEOFF, S_PAGE,
                            S_CSR, S_CBR, S_RP} pgd_state_e;
  pgd_state_e  state_q;
  pgd_tmr_if   tm ();
  pgd_timer u_tmr (.mclk(mclk), .srst(srst), .ce(ce), .t(tm));

  logic [15:0] din_s1_q, din_s2_q;
  logic [23:0] pwr_q;
  logic [15:0] ref_cnt_q;
  logic        ref_pend_q;
  logic [3:0]  init_cnt_q;
  logic [15:0] ras_cnt_q;
  logic [8:0]  open_row_q;
  logic        load_q;
  logic [15:0] load_val_q;
  logic [15:0] wdata_q;
  logic        wr_q, rmw_q, ref_cyc_q;
  logic [1:0]  bytes_q;
  logic        page_hit;

  assign tm.load  = load_q;
  assign tm.count = load_val_q;
  assign page_hit = req_valid && (req_addr[17:9] == open_row_q) && !ref_pend_q
                    && ras_cnt_q < 16'((pgd_pkg::T_RAS_MAX) - pgd_pkg::T_PRWC - 4);

  // Data pins cross in from the device, so they pass two flip-flops.
  always_ff @(posedge mclk) begin
    if (srst) begin
      din_s1_q <= 16'h0;
      din_s2_q <= 16'h0;
    end else if (ce) begin
      din_s1_q <= data_lanes_i;
      din_s2_q <= din_s1_q;
    end
  end

  // Refresh request ticks once per row interval; a tick in the cycle that clears the request is not lost.
  always_ff @(posedge mclk) begin
    if (srst) begin
      ref_cnt_q  <= 16'h0;
      ref_pend_q <= 1'b0;
    end else if (ce) begin
      if (ref_cnt_q == 16'(REF_INTERVAL - 1)) begin
        ref_cnt_q  <= 16'h0;
        ref_pend_q <= 1'b1;
      end else begin
        ref_cnt_q <= ref_cnt_q + 16'h1;
        if (state_q == S_CBR && tm.done) ref_pend_q <= 1'b0;
      end
    end
  end

  // Row-active time, so a page burst closes well before the maximum width.
  always_ff @(posedge mclk) begin
    if (srst) begin
      ras_cnt_q <= 16'h0;
    end else if (ce) begin
      ras_cnt_q <= row_strobe_n ? 16'h0 : ras_cnt_q + 16'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= S_PWR;
      pwr_q <= 24'h0;
      init_cnt_q <= 4'h0;
      init_done <= 1'b0;
      load_q <= 1'b0;
      load_val_q <= 16'h0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0;
      row_strobe_n <= 1'b1;
      lower_column_strobe_n <= 1'b1;
      upper_column_strobe_n <= 1'b1;
      write_enable_n <= 1'b1;
      output_enable_n <= 1'b1;
      mux_addr <= 9'h0;
      data_lanes_o <= 16'h0;
      data_lanes_oe <= 16'h0;
      open_row_q <= 9'h0;
      wr_q <= 1'b0;
      rmw_q <= 1'b0;
      ref_cyc_q <= 1'b0;
      bytes_q <= 2'h0;
      wdata_q <= 16'h0;
    end else if (ce) begin
      load_q <= 1'b0;
      rsp_valid <= 1'b0;
      req_ready <= 1'b0;
      unique case (state_q)
        S_PWR: begin
          pwr_q <= pwr_q + 24'h1;
          if (pwr_q == 24'(POWERUP)) state_q <= S_IDLE;
        end
        S_IDLE: begin
          if (init_cnt_q != 4'(pgd_pkg::INIT_REFRESHES) || ref_pend_q) begin
            lower_column_strobe_n <= 1'b0;
            upper_column_strobe_n <= 1'b0;
            load_q <= 1'b1;
            load_val_q <= 16'(pgd_pkg::T_CSR);
            ref_cyc_q <= 1'b1;
            state_q <= S_CSR;
          end else if (req_valid && !load_q && tm.done) begin
            mux_addr <= req_addr[17:9];
            open_row_q <= req_addr[17:9];
            row_strobe_n <= 1'b0;
            load_q <= 1'b1;
            load_val_q <= 16'(pgd_pkg::T_RAC - pgd_pkg::T_CAC);
            state_q <= S_RAS;
          end
        end
        S_CSR: if (tm.done && !load_q) begin
          row_strobe_n <= 1'b0;
          load_q <= 1'b1;
          load_val_q <= 16'(pgd_pkg::T_RAS_MIN); // covers the hold as well
          state_q <= S_CBR;
        end
        S_CBR: if (tm.done && !load_q) begin
          row_strobe_n <= 1'b1;
          lower_column_strobe_n <= 1'b1;
          upper_column_strobe_n <= 1'b1;
          if (init_cnt_q != 4'(pgd_pkg::INIT_REFRESHES)) init_cnt_q <= init_cnt_q + 4'h1;
          init_done <= (init_cnt_q >= 4'(pgd_pkg::INIT_REFRESHES - 1));
          load_q <= 1'b1;
          load_val_q <= 16'(pgd_pkg::T_RC - pgd_pkg::T_RAS_MIN);
          state_q <= S_RP;
        end
        S_RAS: if (tm.done && !load_q) begin
          // Early write: write enable falls on the same edge as the column strobes.
          mux_addr <= req_addr[8:0];
          wr_q <= req_write;
          rmw_q <= req_rmw && !req_write;
          bytes_q <= req_bytes;
          // The user may move on once the request is taken, so the late write data is kept here.
          wdata_q <= req_wdata;
          write_enable_n <= !req_write;
          output_enable_n <= req_write;
          data_lanes_o <= req_wdata;
          data_lanes_oe <= req_write ? {{8{req_bytes[1]}}, {8{req_bytes[0]}}} : 16'h0;
          lower_column_strobe_n <= !req_bytes[0];
          upper_column_strobe_n <= !req_bytes[1];
          req_ready <= 1'b1;
          load_q <= 1'b1;
          load_val_q <= 16'(pgd_pkg::T_CAC + 2);
          state_q <= S_CAS;
        end
        S_CAS: if (tm.done && !load_q) begin
          if (!wr_q) rsp_rdata <= din_s2_q;
          rsp_valid <= !wr_q;
          if (rmw_q) begin
            rmw_q <= 1'b0;
            wr_q <= 1'b1;
            output_enable_n <= 1'b1;
            load_q <= 1'b1;
            load_val_q <= 16'(pgd_pkg::T_OEZ);
            state_q <= S_OEOFF;
          end else begin
            lower_column_strobe_n <= 1'b1;
            upper_column_strobe_n <= 1'b1;
            output_enable_n <= 1'b1;
            load_q <= 1'b1;
            load_val_q <= 16'(pgd_pkg::T_PC - pgd_pkg::T_CAC - 2);
            state_q <= S_PAGE;
          end
        end
        S_OEOFF: if (tm.done && !load_q) begin
          // Drive only after the device has let go of the lanes.
          // Write enable falls on the same edge that drives the data onto the lanes; the device latches it on that fall.
          data_lanes_o <= wdata_q;
          data_lanes_oe <= {{8{bytes_q[1]}}, {8{bytes_q[0]}}};
          write_enable_n <= 1'b0;
          load_q <= 1'b1;
          load_val_q <= 16'(pgd_pkg::T_PRWC - pgd_pkg::T_CAC - pgd_pkg::T_OEZ - 4);
          state_q <= S_WAIT;
        end
        S_WAIT: if (tm.done && !load_q) begin
          lower_column_strobe_n <= 1'b1;
          upper_column_strobe_n <= 1'b1;
          load_q <= 1'b1;
          load_val_q <= 16'h2;
          state_q <= S_PAGE;
        end
        S_PAGE: if (tm.done && !load_q) begin
          write_enable_n <= 1'b1;
          data_lanes_oe <= 16'h0;
          if (page_hit && ras_cnt_q >= 16'(pgd_pkg::T_RAS_MIN)) begin
            load_q <= 1'b1; // next column in the open row
            load_val_q <= 16'h1;
            state_q <= S_RAS;
          end else if (ras_cnt_q >= 16'(pgd_pkg::T_RAS_MIN) && !page_hit) begin
            row_strobe_n <= 1'b1;
            load_q <= 1'b1;
            load_val_q <= 16'(pgd_pkg::T_RP);
            ref_cyc_q <= 1'b0;
            state_q <= S_RP;
          end
        end
        S_RP: if (tm.done && !load_q) begin
          state_q <= S_IDLE; // all strobes high here
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  property p_precharge;
    @(posedge mclk) disable iff (srst || !ce)
      $rose(row_strobe_n) |-> row_strobe_n [*8] ##1 row_strobe_n [*5];
  endproperty
  a_precharge: assert property (p_precharge) else $error("row precharge too short");

  property p_ras_min;
    @(posedge mclk) disable iff (srst || !ce)
      $rose(row_strobe_n) |-> $past(ras_cnt_q) >= 16'(pgd_pkg::T_RAS_MIN - 1);
  endproperty
  a_ras_min: assert property (p_ras_min) else $error("row strobe too short");

  property p_cbr_setup;
    @(posedge mclk) disable iff (srst || !ce)
      (state_q == S_CBR && $fell(row_strobe_n))
        |-> !$past(lower_column_strobe_n, 3) && !$past(upper_column_strobe_n, 3);
  endproperty
  a_cbr_setup: assert property (p_cbr_setup) else $error("refresh column strobe late");

  property p_early_write;
    @(posedge mclk) disable iff (srst || !ce)
      (!write_enable_n && $fell(lower_column_strobe_n)) |-> output_enable_n;
  endproperty
  a_early_write: assert property (p_early_write) else $error("write with output enabled");

  property p_byte_lane;
    @(posedge mclk) disable iff (srst || !ce)
      (data_lanes_oe[15:8] != 8'h0) |-> !upper_column_strobe_n || state_q == S_PAGE;
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("upper lane driven without strobe");

  property p_ras_max;
    @(posedge mclk) disable iff (srst || !ce)
      ras_cnt_q <= 16'(pgd_pkg::T_RAS_MAX);
  endproperty
  a_ras_max: assert property (p_ras_max) else $error("row strobe held too long");

  property p_init;
    @(posedge mclk) disable iff (srst || !ce)
      (state_q == S_RAS) |-> init_done;
  endproperty
  a_init: assert property (p_init) else $error("access before init refreshes");

  property p_ref_served;
    @(posedge mclk) disable iff (srst || !ce)
      $rose(ref_pend_q) && init_done |-> ##[1:400] (state_q == S_CSR);
  endproperty
  a_ref_served: assert property (p_ref_served) else $error("refresh not served in time");
endmodule : pgd_ctrl

// file: pgd_dram_model.sv
// Behavioural 256K x 16 page-mode memory facing the controller pins, with timing monitors.
// Assumes controller pins change on its clock; undriven lanes show a toggling pattern.
`timescale 1ns/1ns
module pgd_dram_model #(
  parameter int unsigned ACC_NS = 17
) (
  input  wire logic        row_strobe_n,
  input  wire logic        lower_column_strobe_n,
  input  wire logic        upper_column_strobe_n,
  input  wire logic        write_enable_n,
  input  wire logic        output_enable_n,
  input  wire logic [8:0]  mux_addr,
  input  wire logic [15:0] data_lanes_o,
  input  wire logic [15:0] data_lanes_oe,
  output logic [15:0]      data_lanes_i,
  output int unsigned      refresh_count,
  output int unsigned      page_count,
  output int unsigned      violations
);
  logic [15:0] mem [logic [17:0]];
  logic [15:0] rd_q    = 16'h0;
  logic [15:0] float_q = 16'ha5c3;
  logic [15:0] drv;
  logic [8:0]  row_q   = 9'h0;
  logic [17:0] loc_q   = 18'h0;
  logic        cbr_q   = 1'b0;
  logic        valid_q = 1'b0;
  int unsigned cas_in_row = 0;
  realtime     ras_fall = -1000;
  realtime     ras_rise = -1000;
  realtime     cas_fall = -1000;
  wire         cas_n = lower_column_strobe_n & upper_column_strobe_n;

  task automatic store();
    logic [15:0] w;
    w = mem.exists(loc_q) ? mem[loc_q] : 16'h0;
    if (!lower_column_strobe_n) w[7:0] = data_lanes_i[7:0];
    if (!upper_column_strobe_n) w[15:8] = data_lanes_i[15:8];
    mem[loc_q] = w;
  endtask : store

  // A released lane never holds its old value, so a late capture cannot pass by luck.
  always #4 float_q = ~float_q;

  always @(negedge row_strobe_n) begin
    if ($realtime - ras_rise < 50 || $realtime - ras_fall < 130) violations++;
    if (!cas_n && $realtime - cas_fall < 10) violations++;
    ras_fall = $realtime;
    cas_in_row = 0;
    cbr_q = !cas_n;
    refresh_count++;
    #1 if (!cbr_q) row_q = mux_addr;
  end

  always @(posedge row_strobe_n) begin
    if ($realtime - ras_fall < 70 || $realtime - ras_fall > (cas_in_row > 1 ? 100000 : 10000)) violations++;
    ras_rise = $realtime;
  end

  always @(negedge cas_n) begin
    if (!row_strobe_n && cas_in_row > 0 && $realtime - cas_fall < 45) violations++;
    cas_fall = $realtime;
    #1;
    if (!row_strobe_n && !cbr_q) begin
      if (cas_in_row > 0) page_count++;
      cas_in_row++;
      loc_q = {row_q, mux_addr};
      rd_q = mem.exists(loc_q) ? mem[loc_q] : 16'h0;
      if (!write_enable_n) store();
      else begin
        #(ACC_NS - 1);
        valid_q = !cas_n;
      end
    end
  end

  always @(posedge cas_n) begin
    valid_q = 1'b0;
    if (cbr_q && $realtime - ras_fall < 20) violations++;
  end

  always @(negedge write_enable_n) begin
    #1 if (!row_strobe_n && !cas_n && !cbr_q) store();
  end

  assign drv = {{8{!upper_column_strobe_n}}, {8{!lower_column_strobe_n}}}
             & {16{valid_q && !row_strobe_n && write_enable_n && !output_enable_n}};
  assign data_lanes_i = (data_lanes_oe & data_lanes_o) | (~data_lanes_oe & ((drv & rd_q) | (~drv & float_q)));
endmodule : pgd_dram_model

// file: pgd_ctrl_test.sv
// Self-checking bench for the page-mode memory controller against a behavioural memory.
// Assumes shortened power-up and refresh counts so the run stays short.
`timescale 1ns/1ns
module pgd_ctrl_test;
  logic        mclk      = 1'b0;
  logic        srst      = 1'b1;
  logic        ce        = 1'b1;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic        req_rmw   = 1'b0;
  logic [1:0]  req_bytes = 2'h3;
  logic [17:0] req_addr  = 18'h0;
  logic [15:0] req_wdata = 16'h0;
  logic        req_ready, rsp_valid, init_done;
  logic        row_strobe_n, lower_column_strobe_n, upper_column_strobe_n, write_enable_n, output_enable_n;
  logic [8:0]  mux_addr;
  logic [15:0] rsp_rdata, data_lanes_i, data_lanes_o, data_lanes_oe, rd;
  int unsigned refresh_count, page_count, violations;
  int unsigned cycles = 0;
  int unsigned mismatches = 0;
  int unsigned check_count = 0;

  pgd_ctrl #(.REF_INTERVAL(200), .POWERUP(20)) DUT (.*);
  pgd_dram_model #(.ACC_NS(17)) mem_model (.*);

  initial begin
    forever #2 mclk = ~mclk;
  end

  task automatic close_out();
    if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic xfer(input logic wr, input logic rmw, input logic [1:0] bytes, input logic [17:0] addr,
                      input logic [15:0] wdata, output logic [15:0] rdata);
    int n;
    n = 0;
    rdata = 16'hxxxx;
    @(posedge mclk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_rmw   <= rmw;
    req_bytes <= bytes;
    req_addr  <= addr;
    req_wdata <= wdata;
    do @(posedge mclk); while (req_ready !== 1'b1 && ++n < 3000);
    req_valid <= 1'b0;
    if (!wr) begin
      n = 0;
      do @(posedge mclk); while (rsp_valid !== 1'b1 && ++n < 100);
      rdata = rsp_rdata;
    end
  endtask : xfer

  task automatic t_reset();
    int n;
    n = 0;
    repeat (4) @(posedge mclk);
    check({row_strobe_n, lower_column_strobe_n, upper_column_strobe_n, write_enable_n, output_enable_n}, 5'h1f);
    check(data_lanes_oe, 16'h0);
    check(init_done, 1'b0);
    srst <= 1'b0;
    repeat (20) @(posedge mclk);
    check(refresh_count, 0);
    do @(posedge mclk); while (init_done !== 1'b1 && ++n < 2000);
    check(init_done, 1'b1);
    check(refresh_count >= 8, 1'b1);
  endtask : t_reset

  task automatic t_word();
    int unsigned p;
    p = page_count;
    xfer(1'b1, 1'b0, 2'h3, {9'h1a3, 9'h055}, 16'h3c5a, rd);
    xfer(1'b1, 1'b0, 2'h3, {9'h1a3, 9'h056}, 16'hc3a5, rd);
    xfer(1'b0, 1'b0, 2'h3, {9'h1a3, 9'h055}, 16'h0, rd);
    check(rd, 16'h3c5a);
    xfer(1'b0, 1'b0, 2'h3, {9'h1a3, 9'h056}, 16'h0, rd);
    check(rd, 16'hc3a5);
    check(page_count > p, 1'b1);
  endtask : t_word

  task automatic t_bytes();
    logic [17:0] a;
    a = {9'h0aa, 9'h100};
    xfer(1'b1, 1'b0, 2'h3, a, 16'hffff, rd);
    xfer(1'b1, 1'b0, pgd_pkg::BYTE_LOWER, a, 16'haa12, rd);
    xfer(1'b0, 1'b0, 2'h3, a, 16'h0, rd);
    check(rd, 16'hff12);
    xfer(1'b1, 1'b0, pgd_pkg::BYTE_UPPER, a, 16'h34bb, rd);
    xfer(1'b0, 1'b0, pgd_pkg::BYTE_LOWER, a, 16'h0, rd);
    check(rd[7:0], 8'h12);
    check(rd[15:8] != 8'h34, 1'b1);
    xfer(1'b0, 1'b1, 2'h3, a, 16'h5678, rd);
    check(rd, 16'h3412);
    xfer(1'b0, 1'b0, 2'h3, a, 16'h0, rd);
    check(rd, 16'h5678);
  endtask : t_bytes

  task automatic t_rows();
    logic [17:0] a [4] = '{18'h00000, 18'h3ffff, 18'h001ff, 18'h3fe00};
    logic [15:0] d [4] = '{16'h0f0f, 16'hf0f0, 16'h1234, 16'h4321};
    foreach (a[i]) xfer(1'b1, 1'b0, 2'h3, a[i], d[i], rd);
    foreach (a[i]) begin
      xfer(1'b0, 1'b0, 2'h3, a[i], 16'h0, rd);
      check(rd, d[i]);
      check(mem_model.mem[a[i]], d[i]);
    end
  endtask : t_rows

  // Freezes the block while the row strobe is low; nothing may move until the enable returns.
  task automatic t_hold();
    logic [13:0] snap;
    int unsigned r;
    int n;
    n = 0;
    do @(posedge mclk); while (row_strobe_n !== 1'b0 && ++n < 400);
    r = refresh_count;
    snap = {row_strobe_n, lower_column_strobe_n, upper_column_strobe_n, write_enable_n, output_enable_n, mux_addr};
    ce <= 1'b0;
    repeat (100) @(posedge mclk);
    check({row_strobe_n, lower_column_strobe_n, upper_column_strobe_n, write_enable_n, output_enable_n, mux_addr},
          snap);
    check(refresh_count, r);
    ce <= 1'b1;
  endtask : t_hold

  task automatic t_idle();
    int unsigned r;
    r = refresh_count;
    repeat (1000) @(posedge mclk);
    check(refresh_count - r >= 4, 1'b1);
    check(data_lanes_oe, 16'h0);
    check(violations, 0);
  endtask : t_idle

  initial begin
    t_reset();
    t_word();
    t_bytes();
    t_rows();
    t_hold();
    t_idle();
    close_out();
  end
endmodule : pgd_ctrl_test
